/* core/jsd_status_decode.sv */
// Purpose: Debug-port instruction decoding and status reporting for the scan link.
// Assumes: Scan clock, mode and data pins are asynchronous to clk and are sampled here.
// Notes:   The service bus itself lives outside; it reports start, done and fail.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// What this block does
// - Error updates on access end, clears on start
// - Instruction still selected while error set
// - Address accepted, read started despite error
// - Error during read data marks data invalid
// - Write data accepted; no address-to-data error
// - Error bit set after power-up
// - Protected while flash controller held in reset
// - Protected until security bit read after release
// - Protected while security bit programmed
// - 0x01 selects 32-bit identification register
// - 0x02 sample, 0x03 external, 0x04 internal test
// - 0x06 bypass while boundary chain drives pins
// - 0x0C static reset, 0x0F erase, 0x1C halt
// - 0x10/11/14/15 select address and data registers
// - 0x12 data only with auto-increment
// - 0x13 cancels access, 0x17 selects sync counter
// - Fuse programmed restricts memory-access instructions except 0x14
// - Erase clears fuse, restoring full access
// - Static reset reads as fuse programmed
// - Capture shifts out p,e,b,0,1 least first
// - Error bit reads one after error
module jsd_status_decode #(
  parameter int SECRD_CYCLES = jsd_pkg::SECRD_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdoEn,
  input  wire logic              resetLineN,
  input  wire logic              svcBusy,
  input  wire jsd_pkg::jsd_svc_t svcEvt,
  output jsd_pkg::jsd_dec_t      decode,
  output logic                   accessStart,
  output logic                   flashRst,
  output logic                   eraseReq,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr
);
  import jsd_pkg::*;

  // Refuse a security read delay that the counter cannot serve.
  if (SECRD_CYCLES < 1) begin : gBadSecrd
    $error("SECRD_CYCLES must be at least one");
  end

  // ==========================================================================
  // Instruction decode
  // ==========================================================================
  // Map one instruction code onto its data register and side effects.
  function automatic jsd_dec_t decodeOp(input logic [4:0] op, input logic locked);
    jsd_dec_t d;
    d = '0;
    d.dr = DR_BYPASS;
    d.amode = AM_TRACE;
    unique case (op)
      OP_IDCODE: d.dr = DR_IDCODE;
      OP_SAMPLE: begin
        d.dr = DR_BOUNDARY;
        d.sampleOnly = 1'b1;
      end
      OP_EXTEST: begin
        d.dr = DR_BOUNDARY;
        d.extTest = 1'b1;
      end
      OP_INTEST: begin
        d.dr = DR_BOUNDARY;
        d.intTest = 1'b1;
      end
      OP_CLAMP: d.clampPins = 1'b1;
      OP_STATRST: d.staticRst = 1'b1;
      OP_ERASE: d.erase = 1'b1;
      OP_HALT: d.halt = 1'b1;
      OP_NEXUS: begin
        d.dr = DR_ADDRDATA;
        d.amode = AM_TRACE;
        d.restricted = locked;
      end
      OP_WORD: begin
        d.dr = DR_ADDRDATA;
        d.amode = AM_WORD;
        d.restricted = locked;
      end
      OP_MEMSVC: begin
        d.dr = DR_ADDRDATA;
        d.amode = AM_SVC;
      end
      OP_SIZED: begin
        d.dr = DR_ADDRDATA;
        d.amode = AM_SIZED;
        d.restricted = locked;
      end
      OP_BLOCK: begin
        d.dr = DR_DATA;
        d.autoInc = 1'b1;
        d.restricted = locked;
      end
      OP_CANCEL: d.cancel = 1'b1;
      OP_SYNC: d.dr = DR_SYNC;
      default: d.dr = DR_BYPASS;
    endcase
    return d;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [2:0] pinMeta_reg;
  logic [2:0] pinSync_reg;
  logic       tckPrev_reg;
  logic       tckRise;
  logic       tckFall;

  // Two flip-flops on each scan pin before any logic looks at it.
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_reg <= 3'h0;
      pinSync_reg <= 3'h0;
      tckPrev_reg <= 1'b0;
    end else begin
      pinMeta_reg <= {tck, tms, tdi};
      pinSync_reg <= pinMeta_reg;
      tckPrev_reg <= pinSync_reg[2];
    end
  end

  assign tckRise = pinSync_reg[2] & ~tckPrev_reg;
  assign tckFall = ~pinSync_reg[2] & tckPrev_reg;

  // ==========================================================================
  // Test access port controller
  // ==========================================================================
  typedef enum logic [15:0] {
    TS_RESET  = 16'h0001, TS_IDLE   = 16'h0002, TS_SELDR  = 16'h0004,
    TS_CAPDR  = 16'h0008, TS_SHDR   = 16'h0010, TS_EX1DR  = 16'h0020,
    TS_PSDR   = 16'h0040, TS_EX2DR  = 16'h0080, TS_UPDR   = 16'h0100,
    TS_SELIR  = 16'h0200, TS_CAPIR  = 16'h0400, TS_SHIR   = 16'h0800,
    TS_EX1IR  = 16'h1000, TS_PSIR   = 16'h2000, TS_EX2IR  = 16'h4000,
    TS_UPIR   = 16'h8000
  } jsd_tap_t;

  jsd_tap_t tap_reg;
  jsd_tap_t tap_next;
  logic     tmsS;

  // Mode pin as seen after its synchroniser.
  assign tmsS = pinSync_reg[1];

  // Standard sixteen-state walk driven by the mode pin.
  always_comb begin
    tap_next = tap_reg;
    unique case (tap_reg)
      TS_RESET: tap_next = tmsS ? TS_RESET : TS_IDLE;
      TS_IDLE:  tap_next = tmsS ? TS_SELDR : TS_IDLE;
      TS_SELDR: tap_next = tmsS ? TS_SELIR : TS_CAPDR;
      TS_CAPDR: tap_next = tmsS ? TS_EX1DR : TS_SHDR;
      TS_SHDR:  tap_next = tmsS ? TS_EX1DR : TS_SHDR;
      TS_EX1DR: tap_next = tmsS ? TS_UPDR : TS_PSDR;
      TS_PSDR:  tap_next = tmsS ? TS_EX2DR : TS_PSDR;
      TS_EX2DR: tap_next = tmsS ? TS_UPDR : TS_SHDR;
      TS_UPDR:  tap_next = tmsS ? TS_SELDR : TS_IDLE;
      TS_SELIR: tap_next = tmsS ? TS_RESET : TS_CAPIR;
      TS_CAPIR: tap_next = tmsS ? TS_EX1IR : TS_SHIR;
      TS_SHIR:  tap_next = tmsS ? TS_EX1IR : TS_SHIR;
      TS_EX1IR: tap_next = tmsS ? TS_UPIR : TS_PSIR;
      TS_PSIR:  tap_next = tmsS ? TS_EX2IR : TS_PSIR;
      TS_EX2IR: tap_next = tmsS ? TS_UPIR : TS_SHIR;
      TS_UPIR:  tap_next = tmsS ? TS_SELDR : TS_IDLE;
      default:  tap_next = TS_RESET;
    endcase
  end

  // State advances on each rising scan clock edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      tap_reg <= TS_RESET;
    end else if (tckRise) begin
      tap_reg <= tap_next;
    end
  end

  // ==========================================================================
  // Protection and error status
  // ==========================================================================
  logic        err_reg;
  logic        fuse_reg;
  logic        secRead_reg;
  logic [31:0] secCnt_reg;
  logic        statRst_reg;
  logic [1:0]  rstLineMeta_reg;
  logic [1:0]  rstLineSync_reg;
  logic        protected_;
  logic        fuseSet;
  logic        fuseClr;

  assign flashRst = statRst_reg | ~rstLineSync_reg[1];
  assign protected_ = flashRst | ~secRead_reg | fuse_reg;

  // Reset line passes four flip-flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      rstLineMeta_reg <= 2'h0;
      rstLineSync_reg <= 2'h0;
    end else begin
      rstLineMeta_reg <= {resetLineN, rstLineMeta_reg[1]};
      rstLineSync_reg <= {rstLineSync_reg[0], rstLineMeta_reg[0]};
    end
  end

  // Security bit read counts up after the flash controller leaves reset.
  always_ff @(posedge clk) begin
    if (rst || flashRst) begin
      secCnt_reg  <= 32'h0;
      secRead_reg <= 1'b0;
    end else if (!secRead_reg) begin
      if (secCnt_reg >= 32'(SECRD_CYCLES - 1)) begin
        secRead_reg <= 1'b1;
      end
      secCnt_reg <= secCnt_reg + 32'h1;
    end
  end

  // Error sets on failed completion, clears on start, and is set at power-up.
  always_ff @(posedge clk) begin
    if (rst) begin
      err_reg <= 1'b1;
    end else if (svcEvt.done) begin
      err_reg <= svcEvt.fail;
    end else if (svcEvt.start) begin
      err_reg <= 1'b0;
    end
  end

  // Fuse is set by software and wiped only by reset or the erase instruction.
  always_ff @(posedge clk) begin
    if (rst) begin
      fuse_reg <= 1'b0;
    end else if (fuseSet) begin
      fuse_reg <= 1'b1;
    end else if (fuseClr) begin
      fuse_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Shift paths and instruction register
  // ==========================================================================
  logic [4:0]  irShift_reg;
  logic [4:0]  ir_reg;
  logic        dataBit_reg;
  logic        locked;
  logic        tdiS;

  assign tdiS = pinSync_reg[0];
  assign locked = fuse_reg | flashRst;

  // Capture status, shift least bit first, and latch the code on update.
  always_ff @(posedge clk) begin
    if (rst) begin
      irShift_reg <= 5'h0;
      ir_reg      <= OP_IDCODE;
    end else if (tckRise) begin
      unique case (tap_reg)
        TS_RESET: ir_reg <= OP_IDCODE;
        TS_CAPIR: irShift_reg <= {protected_, err_reg, svcBusy, ST_TAIL};
        TS_SHIR:  irShift_reg <= {tdiS, irShift_reg[4:1]};
        TS_UPIR:  ir_reg <= irShift_reg;
        default:  irShift_reg <= irShift_reg;
      endcase
    end
  end

  // Serial output changes on the falling scan clock edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      tdo   <= 1'b0;
      tdoEn <= 1'b0;
    end else if (tckFall) begin
      tdoEn <= (tap_reg == TS_SHIR) || (tap_reg == TS_SHDR);
      tdo   <= (tap_reg == TS_SHIR) ? irShift_reg[0] : dataBit_reg;
    end
  end

  // Bypass bit holds the first data bit; other chains live outside.
  always_ff @(posedge clk) begin
    if (rst) begin
      dataBit_reg <= 1'b0;
    end else if (tckRise) begin
      if (tap_reg == TS_CAPDR) begin
        dataBit_reg <= protected_;
      end else if (tap_reg == TS_SHDR) begin
        dataBit_reg <= tdiS;
      end
    end
  end

  // ==========================================================================
  // Decoded outputs
  // ==========================================================================
  // Decode is registered so downstream logic sees a stable code.
  always_ff @(posedge clk) begin
    if (rst) begin
      decode      <= decodeOp(OP_IDCODE, 1'b0);
      accessStart <= 1'b0;
      statRst_reg <= 1'b0;
      eraseReq    <= 1'b0;
    end else begin
      decode <= decodeOp(ir_reg, locked);
      // an update launches a new access even with error set.
      accessStart <= tckRise && (tap_reg == TS_UPDR) &&
                     (decode.dr == DR_ADDRDATA || decode.dr == DR_DATA) && !svcBusy;
      if (tckRise && tap_reg == TS_UPDR && ir_reg == OP_STATRST) begin
        statRst_reg <= dataBit_reg;
      end
      eraseReq <= tckRise && (tap_reg == TS_UPIR) && (irShift_reg == OP_ERASE);
    end
  end

  // Erasing the whole device also wipes the fuse.
  assign fuseClr = eraseReq;

  // ==========================================================================
  // APB register slave
  // ==========================================================================
  logic wrEn;

  assign wrEn    = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && paddr != ADDR_CTRL && paddr != ADDR_STATUS
                   && paddr != ADDR_INSTR;
  assign fuseSet = wrEn && paddr == ADDR_CTRL && pwdata[CTRL_FUSE];

  // Read data is registered from the block's own state.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL:   prdata <= {31'h0, fuse_reg};
        ADDR_STATUS: prdata <= {27'h0, protected_, err_reg, svcBusy, ST_TAIL};
        ADDR_INSTR:  prdata <= {27'h0, ir_reg};
        default:     prdata <= 32'h0;
      endcase
    end
  end

endmodule

/* pkg/jsd_pkg.sv */
// Purpose: Shared constants and types for the debug-port status and opcode decoder.
// Assumes: Five-bit instruction register, status shifted least significant bit first.
// Notes:   Register offsets are byte addresses on a 32-bit APB bus.
package jsd_pkg;

  // ==========================================================================
  // Instruction codes
  // ==========================================================================
  localparam int          IR_W         = 5;
  localparam logic [4:0]  OP_IDCODE    = 5'h01;
  localparam logic [4:0]  OP_SAMPLE    = 5'h02;
  localparam logic [4:0]  OP_EXTEST    = 5'h03;
  localparam logic [4:0]  OP_INTEST    = 5'h04;
  localparam logic [4:0]  OP_CLAMP     = 5'h06;
  localparam logic [4:0]  OP_STATRST   = 5'h0c;
  localparam logic [4:0]  OP_ERASE     = 5'h0f;
  localparam logic [4:0]  OP_NEXUS     = 5'h10;
  localparam logic [4:0]  OP_WORD      = 5'h11;
  localparam logic [4:0]  OP_BLOCK     = 5'h12;
  localparam logic [4:0]  OP_CANCEL    = 5'h13;
  localparam logic [4:0]  OP_MEMSVC    = 5'h14;
  localparam logic [4:0]  OP_SIZED     = 5'h15;
  localparam logic [4:0]  OP_SYNC      = 5'h17;
  localparam logic [4:0]  OP_HALT      = 5'h1c;
  localparam logic [4:0]  OP_BYPASS    = 5'h1f;

  // ==========================================================================
  // Data register selection
  // ==========================================================================
  typedef enum logic [5:0] {
    DR_BYPASS   = 6'h01,
    DR_IDCODE   = 6'h02,
    DR_BOUNDARY = 6'h04,
    DR_ADDRDATA = 6'h08,
    DR_DATA     = 6'h10,
    DR_SYNC     = 6'h20
  } jsd_dr_t;

  // Service bus access mode presented with an address/data selection.
  typedef enum logic [1:0] {
    AM_TRACE = 2'h0,
    AM_WORD  = 2'h1,
    AM_SVC   = 2'h2,
    AM_SIZED = 2'h3
  } jsd_amode_t;

  // Full decode of one instruction.
  typedef struct packed {
    jsd_dr_t    dr;
    jsd_amode_t amode;
    logic       sampleOnly;
    logic       extTest;
    logic       intTest;
    logic       clampPins;
    logic       staticRst;
    logic       erase;
    logic       halt;
    logic       cancel;
    logic       autoInc;
    logic       restricted;
  } jsd_dec_t;

  // Service bus start and completion report.
  typedef struct packed {
    logic start;
    logic done;
    logic fail;
  } jsd_svc_t;

  // ==========================================================================
  // Status pattern and timing
  // ==========================================================================
  localparam int          ST_PROT_BIT  = 4;
  localparam int          ST_ERR_BIT   = 3;
  localparam int          ST_BUSY_BIT  = 2;
  localparam logic [1:0]  ST_TAIL      = 2'h1;
  localparam int          CLK_MHZ      = 20;
  localparam int          SECRD_US     = 3000;
  localparam int          SECRD_CYC    = SECRD_US * CLK_MHZ;

  // ==========================================================================
  // APB register map
  // ==========================================================================
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_INSTR   = 8'h08;
  localparam int          CTRL_FUSE    = 0;
  localparam int          CTRL_CLRFUSE = 1;

endpackage

/* sim/jsd_status_decode_props.sv */
// Purpose: Port-level checks for the debug-port status and opcode decoder.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Attached to the design by the bind after the module.
`timescale 1ns/1ps
module jsd_status_decode_props #(
  parameter int SECRD_CYCLES = jsd_pkg::SECRD_CYC
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              resetLineN,
  input wire logic              svcBusy,
  input wire jsd_pkg::jsd_dec_t decode,
  input wire logic              accessStart,
  input wire logic              flashRst,
  input wire logic              eraseReq,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr
);
  import jsd_pkg::*;
  // ============================================================
  // Properties
  // ============================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic unmapped;
  logic memOp;
  // Flags APB places outside the map and selections that the fuse restricts.
  assign unmapped = !(paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_INSTR});
  assign memOp    = decode.dr == DR_DATA || (decode.dr == DR_ADDRDATA && decode.amode != AM_SVC);
  property p_line_rst;
    !resetLineN [*5] |-> flashRst;
  endproperty
  a_line_rst: assert property (p_line_rst) else $error("reset line low without flash reset");
  property p_restrict;
    flashRst [*4] ##0 memOp |-> decode.restricted;
  endproperty
  a_restrict: assert property (p_restrict) else $error("access open under flash reset");
  property p_start;
    accessStart |-> (decode.dr inside {DR_ADDRDATA, DR_DATA}) ##1 !accessStart;
  endproperty
  a_start: assert property (p_start) else $error("bad access start pulse");
  property p_start_busy;
    svcBusy [*2] |-> !accessStart;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("access started while busy");
  property p_erase;
    eraseReq |-> ##[0:2] decode.erase ##1 !eraseReq;
  endproperty
  a_erase: assert property (p_erase) else $error("erase pulse without erase decode");
  property p_onehot;
    $onehot(decode.dr);
  endproperty
  a_onehot: assert property (p_onehot) else $error("data register selection not one-hot");
  property p_clamp;
    decode.clampPins |-> decode.dr == DR_BYPASS;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp without bypass path");
  property p_boundary;
    decode.sampleOnly || decode.extTest || decode.intTest |-> decode.dr == DR_BOUNDARY;
  endproperty
  a_boundary: assert property (p_boundary) else $error("boundary mode off the chain");
  property p_autoinc;
    decode.autoInc |-> decode.dr == DR_DATA;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("auto-increment off the data path");
  property p_unmapped;
    psel && !penable && !pwrite && unmapped |-> ##1 pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  // Main scenarios reached.
  c_start: cover property (accessStart);
  c_erase: cover property (eraseReq);
  c_restrict: cover property (flashRst && decode.restricted);
endmodule
bind jsd_status_decode jsd_status_decode_props #(.SECRD_CYCLES(SECRD_CYCLES)) u_props (
  .clk(clk), .rst(rst), .resetLineN(resetLineN), .svcBusy(svcBusy), .decode(decode),
  .accessStart(accessStart), .flashRst(flashRst), .eraseReq(eraseReq), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr)
);

/* sim/jsd_jtag_ctl.sv */
// Purpose: Behavioural scan-link controller driving the test pins.
// Assumes: Link period of eight system clocks, clock parked low between scans.
// Notes:   Mode and data change at the start of the low phase.
`timescale 1ns/1ps
module jsd_jtag_ctl (
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  logic q;
  // Pins start idle with the link clock low.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One link period: five clocks low, three high; tdo is read just before the rise.
  task automatic tick(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge clk);
    o = tdo;
    tck <= 1'b1;
    repeat (3) @(posedge clk);
    tck <= 1'b0;
  endtask
  // Walks mode bits, first in bit 0; the unused data line toggles so no level lingers.
  task automatic walk(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      tick(v[i], ~tdi, q);
    end
  endtask
  // Five ones reach test-logic-reset, a zero parks in idle.
  task automatic reset_tap();
    walk(8'h1f, 6);
  endtask
  // Loads an instruction and returns the captured status, first bit in bit 0.
  // A set error seen here belongs to the last access of the old instruction.
  task automatic scan_ir(input logic [4:0] c, output logic [4:0] s);
    walk(8'h03, 4);
    for (int i = 0; i < 5; i++) begin
      tick(i == 4, c[i], s[i]);
    end
    walk(8'h01, 2);
    // Let the registered decode and pulses settle before the caller looks.
    repeat (2) @(posedge clk);
  endtask
  // Shifts one data bit and passes through update back to idle.
  task automatic scan_dr(input logic d);
    walk(8'h01, 3);
    tick(1'b1, d, q);
    walk(8'h01, 2);
    repeat (2) @(posedge clk);
  endtask
endmodule

/* sim/jsd_status_decode_tb.sv */
// Purpose: Self-checking bench for the debug-port status and opcode decoder.
// Assumes: Security read delay shortened to ten clocks.
// Notes:   The bench plays the service bus and the APB master.
`timescale 1ns/1ps
module jsd_status_decode_tb;
  import jsd_pkg::*;
  localparam int SRD = 10;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        resetLineN = 1'b1;
  logic        svcBusy = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  jsd_svc_t    svcEvt = '0;
  logic        tck, tms, tdi, tdo, tdoEn, accessStart, flashRst, eraseReq, pready, pslverr, se;
  logic [31:0] prdata, rd;
  logic [4:0]  st;
  jsd_dec_t    decode;
  int          fails = 0;
  int          samples_checked = 0;
  int          starts = 0;
  int          erases = 0;
  int          ens = 0;
  logic [4:0]  ops [17] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h10, 5'h11, 5'h12, 5'h13,
                            5'h14, 5'h15, 5'h17, 5'h1c, 5'h1f, 5'h00, 5'h05, 5'h1e};
  jsd_svc_t    evs [4] = '{3'h4, 3'h3, 3'h7, 3'h2};
  logic [3:0]  exs = 4'h6;

  jsd_status_decode #(.SECRD_CYCLES(SRD)) uut (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn),
    .resetLineN(resetLineN), .svcBusy(svcBusy), .svcEvt(svcEvt), .decode(decode),
    .accessStart(accessStart), .flashRst(flashRst), .eraseReq(eraseReq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  jsd_jtag_ctl ctl (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  // ============================================================
  // Clock, pulse counters and helpers
  // ============================================================
  always #25 clk = ~clk;
  // Counts access starts, erase pulses and cycles with the serial output driven.
  always @(posedge clk) begin
    if (accessStart === 1'b1) starts++;
    if (eraseReq === 1'b1) erases++;
    if (tdoEn === 1'b1) ens++;
  end
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; data and response are taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int waits;
    waits = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      waits++;
      @(posedge clk);
    end
    rd = prdata;
    se = pslverr;
    chk("wait states", waits, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [4:0] pat(input logic p, input logic e, input logic b);
    pat = {p, e, b, ST_TAIL};
  endfunction
  task automatic sts(input logic [4:0] e);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, {27'h0, e});
  endtask
  task automatic pulse(input jsd_svc_t v);
    @(posedge clk);
    svcEvt <= v;
    @(posedge clk);
    svcEvt <= '0;
  endtask
  function automatic logic [14:0] seen();
    seen = {decode.dr, decode.dr == DR_ADDRDATA ? decode.amode : AM_TRACE, decode.sampleOnly,
            decode.extTest, decode.intTest, decode.clampPins, decode.halt, decode.cancel,
            decode.autoInc};
  endfunction
  function automatic logic [14:0] want(input logic [4:0] c);
    jsd_dr_t    r;
    jsd_amode_t m;
    logic [6:0] f;
    f = {c == OP_SAMPLE, c == OP_EXTEST, c == OP_INTEST, c == OP_CLAMP, c == OP_HALT,
         c == OP_CANCEL, c == OP_BLOCK};
    m = c == OP_WORD ? AM_WORD : c == OP_MEMSVC ? AM_SVC : c == OP_SIZED ? AM_SIZED : AM_TRACE;
    case (c)
      OP_IDCODE: r = DR_IDCODE;
      OP_SAMPLE, OP_EXTEST, OP_INTEST: r = DR_BOUNDARY;
      OP_NEXUS, OP_WORD, OP_MEMSVC, OP_SIZED: r = DR_ADDRDATA;
      OP_BLOCK: r = DR_DATA;
      OP_SYNC: r = DR_SYNC;
      default: r = DR_BYPASS;
    endcase
    want = {r, m, f};
  endfunction
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end

  // ============================================================
  // Test sequence
  // ============================================================
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ctl.reset_tap();
    // The controller sees the power-up error on every capture; nothing clears it yet.
    foreach (ops[i]) begin
      ctl.scan_ir(ops[i], st);
      chk("ir status", st, pat(1'b0, 1'b1, 1'b0));
      chk("decode", seen(), want(ops[i]));
    end
    for (int i = 0; i < 4; i++) begin
      pulse(evs[i]);
      sts(pat(1'b0, exs[i], 1'b0));
    end
    svcBusy <= 1'b1;
    ens = 0;
    ctl.scan_ir(OP_WORD, st);
    chk("busy capture", st, pat(1'b0, 1'b0, 1'b1));
    chk("drive window", ens, 40);
    ctl.scan_dr(1'b1);
    chk("start while busy", starts, 0);
    svcBusy <= 1'b0;
    pulse(3'h3);
    ctl.scan_dr(1'b0);
    chk("start despite error", starts, 1);
    ctl.scan_ir(OP_CANCEL, st);
    chk("cancel error", st, pat(1'b0, 1'b1, 1'b0));
    chk("cancel decode", decode.cancel, 1'b1);
    ctl.scan_ir(OP_BLOCK, st);
    ctl.scan_dr(1'b1);
    chk("block start", starts, 2);
    pulse(3'h2);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("fuse", rd[CTRL_FUSE], 1'b1);
    sts(pat(1'b1, 1'b0, 1'b0));
    ctl.scan_ir(OP_SIZED, st);
    chk("protected capture", st, pat(1'b1, 1'b0, 1'b0));
    chk("restricted", decode.restricted, 1'b1);
    ctl.scan_ir(OP_MEMSVC, st);
    chk("service open", decode.restricted, 1'b0);
    ctl.scan_ir(OP_ERASE, st);
    chk("erase pulse", erases, 1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("fuse cleared", rd[CTRL_FUSE], 1'b0);
    ctl.scan_ir(OP_NEXUS, st);
    chk("open again", decode.restricted, 1'b0);
    ctl.scan_ir(OP_STATRST, st);
    ctl.scan_dr(1'b1);
    chk("static reset", flashRst, 1'b1);
    ctl.scan_ir(OP_WORD, st);
    chk("reset capture", st, pat(1'b1, 1'b0, 1'b0));
    chk("reset restricts", decode.restricted, 1'b1);
    resetLineN <= 1'b0;
    ctl.scan_ir(OP_STATRST, st);
    ctl.scan_dr(1'b0);
    chk("line holds reset", flashRst, 1'b1);
    resetLineN <= 1'b1;
    wait (flashRst === 1'b0);
    sts(pat(1'b1, 1'b0, 1'b0));
    repeat (4 * SRD) @(posedge clk);
    chk("released", flashRst, 1'b0);
    sts(pat(1'b0, 1'b0, 1'b0));
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped error", se, 1'b1);
    apb(1'b0, ADDR_INSTR, 32'h0);
    chk("instruction", rd, {27'h0, OP_STATRST});
    complete_run();
  end
endmodule
